// ### common/rtc_defines.svh
// register offsets, field positions and timing counts of the calendar clock
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
// register word offsets (16-bit data)
`define OFS_CFG 4'h0
`define OFS_VALH 4'h1
`define OFS_VALL 4'h2
`define OFS_ALMCFG 4'h3
`define OFS_ALMH 4'h4
`define OFS_ALML 4'h5
`define OFS_KEY 4'h6
`define OFS_PAD 4'h7
`define OFS_IRQ_ST 4'h8
`define OFS_IRQ_MASK 4'h9
// configuration register fields
`define CFG_ON_BIT 15
`define CFG_UNLOCK_BIT 13
`define CFG_HALF_BIT 11
`define CFG_OE_BIT 10
// alarm configuration fields
`define ALM_EN_BIT 15
`define ALM_CHIME_BIT 14
// unlock key values
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
// one instruction cycle of the window, in core clocks
`define KEY_WINDOW_CYC 2'h2
// calibration: pulses per code step, one minute of seconds
`define CAL_STEP 4
`define SEC_PER_MIN 6'h3B
`endif

// ### common/rtc_pkg.sv
// types shared by the calendar clock
package rtc_pkg;
   typedef struct packed
   {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] day;
      logic [7:0] month;
      logic [7:0] year;
   } time_s;
   typedef struct packed
   {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] day;
      logic [7:0] month;
   } alarm_s;
   typedef enum logic [2:0]
   {
      KEY_IDLE = 3'b001,
      KEY_GOT55 = 3'b010,
      KEY_OPEN = 3'b100
   } key_state_e;
endpackage

// ### design/calendar_clock.sv
// bcd calendar clock with alarm, calibration and windowed register access
`include "rtc_defines.svh"
`default_nettype none
// What this block does
// - hours run 00 to 23, no am/pm
// - weekday, day, month, two-digit year covering 2000 to 2099
// - leap years insert 29 february automatically
// - every time, calendar and alarm field is bcd
// - one-second count plus a readable half-second flag
// - seconds derived from a separate 32.768 khz timebase
// - signed calibration adds or removes pulses once per minute
// - output pin carries alarm pulse or seconds clock, software chosen
// - 2-bit value pointer picks the pair shown in the time window
// - high-byte write to time window decrements pointer, stops at 00
// - 2-bit alarm pointer picks the alarm pair, code 11 is empty
// - high-byte write to alarm window decrements pointer, stops at 00
// - reads of either byte decrement pointers; only high writes do
// - time writes ignored unless the write-unlock bit is set
// - unlock bit settable only right after 55h then AAh key writes
// - module-on bit writable only while unlock is set
// - half-second flag read-only, cleared by writing seconds byte
module calendar_clock
   import rtc_pkg::*;
#(
   parameter int TICKS_PER_SEC = 32768
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // 32.768 khz timebase pin
   input wire logic timebase_in,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_byte_en,
   output logic [15:0] reg_rdata,
   // output pin and interrupt
   output logic rtc_pin,
   output logic irq
);
   // bcd increment with wrap to a given floor past a given top
   function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] floor_v);
      if (v >= top)
         bcd_inc = floor_v;
      else if (v[3:0] == 4'h9)
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
   endfunction

   // last day of a month in bcd
   function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      leap = 1'b0;
      // bcd year divisible by 4: tens even with ones 0/4/8, tens odd with 2/6
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      unique case (m)
         8'h02: month_end = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
         default: month_end = 8'h31;
      endcase
   endfunction

   // ==========================================================
   // timebase synchroniser and edge detect
   logic tb_meta_r, tb_sync_r, tb_prev_r;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tb_meta_r <= 1'b0;
         tb_sync_r <= 1'b0;
         tb_prev_r <= 1'b0;
      end
      else
      begin
         tb_meta_r <= timebase_in;
         tb_sync_r <= tb_meta_r;
         tb_prev_r <= tb_sync_r;
      end
   end
   // one enable per timebase rising edge
   wire tick = tb_sync_r & ~tb_prev_r;

   // ==========================================================
   // registers
   logic [15:0] cfg_r;
   logic [15:0] alm_cfg_r;
   logic pad_sel_r;
   logic [1:0] irq_st_r, irq_mask_r;
   time_s tm_r;
   alarm_s al_r;
   key_state_e key_r;
   logic [1:0] key_cnt_r;
   logic [15:0] sub_r;
   logic [9:0] cal_pend_r;
   logic [5:0] min_sec_r;
   logic sec_clk_r, alarm_pulse_r;
   // declared early: the alarm repeat logic reads it before its decode below
   logic alarm_hit;

   wire [1:0] vptr = cfg_r[9:8];
   wire [1:0] aptr = alm_cfg_r[9:8];
   wire unlocked = cfg_r[`CFG_UNLOCK_BIT];
   wire on = cfg_r[`CFG_ON_BIT];

   // bus decode
   wire wr_cfg = reg_wr && reg_addr == `OFS_CFG;
   wire wr_valh = reg_wr && reg_addr == `OFS_VALH;
   wire wr_vall = reg_wr && reg_addr == `OFS_VALL;
   wire wr_acfg = reg_wr && reg_addr == `OFS_ALMCFG;
   wire wr_almh = reg_wr && reg_addr == `OFS_ALMH;
   wire wr_alml = reg_wr && reg_addr == `OFS_ALML;
   wire wr_key = reg_wr && reg_addr == `OFS_KEY && reg_byte_en[0];
   wire rd_val = reg_rd && (reg_addr == `OFS_VALH || reg_addr == `OFS_VALL);
   wire rd_alm = reg_rd && (reg_addr == `OFS_ALMH || reg_addr == `OFS_ALML);
   // time field writes need the unlock bit
   wire tw_h = wr_valh && unlocked;
   wire tw_l = wr_vall && unlocked;
   // unlock may be set only inside the key window
   wire key_open = key_r == KEY_OPEN;

   // ==========================================================
   // 55h then AAh opens a short window
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         key_r <= KEY_IDLE;
         key_cnt_r <= 2'h0;
      end
      else
      begin
         unique case (key_r)
            KEY_IDLE:
               if (wr_key && reg_wdata[7:0] == `KEY_FIRST)
                  key_r <= KEY_GOT55;
            KEY_GOT55:
               if (wr_key)
               begin
                  key_r <= (reg_wdata[7:0] == `KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
                  key_cnt_r <= `KEY_WINDOW_CYC;
               end
               else if (reg_wr)
                  key_r <= KEY_IDLE;
            KEY_OPEN:
            begin
               key_cnt_r <= key_cnt_r - 2'h1;
               if (key_cnt_r == 2'h1 || reg_wr)
                  key_r <= KEY_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // configuration, pointer and alarm configuration registers
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_r <= 16'h0000;
         alm_cfg_r <= 16'h0000;
         pad_sel_r <= 1'b0;
         irq_mask_r <= 2'h0;
      end
      else
      begin
         if (wr_cfg)
         begin
            // unlock sets only in window, clears any time
            if (!reg_wdata[`CFG_UNLOCK_BIT] || key_open)
               cfg_r[`CFG_UNLOCK_BIT] <= reg_wdata[`CFG_UNLOCK_BIT];
            if (unlocked)
               cfg_r[`CFG_ON_BIT] <= reg_wdata[`CFG_ON_BIT];
            cfg_r[`CFG_OE_BIT] <= reg_wdata[`CFG_OE_BIT];
            cfg_r[9:0] <= reg_wdata[9:0];
         end
         // value pointer steps down, holds at 00
         else if ((tw_h || rd_val) && vptr != 2'h0)
            cfg_r[9:8] <= vptr - 2'h1;
         if (wr_acfg)
            alm_cfg_r <= reg_wdata;
         // alarm pointer steps down, holds at 00
         else if ((wr_almh || rd_alm) && aptr != 2'h0)
            alm_cfg_r[9:8] <= aptr - 2'h1;
         else if (alarm_hit && alm_cfg_r[7:0] != 8'h00)
            alm_cfg_r[7:0] <= alm_cfg_r[7:0] - 8'h01;
         else if (alarm_hit && alm_cfg_r[`ALM_CHIME_BIT])
            alm_cfg_r[7:0] <= 8'hFF;
         else if (alarm_hit)
            alm_cfg_r[`ALM_EN_BIT] <= 1'b0;
         if (reg_wr && reg_addr == `OFS_PAD)
            pad_sel_r <= reg_wdata[1];
         if (reg_wr && reg_addr == `OFS_IRQ_MASK)
            irq_mask_r <= reg_wdata[1:0];
      end
   end

   // ==========================================================
   // calibration: cal code times 4 pulses, applied once a minute
   wire [7:0] cal = cfg_r[7:0];
   wire [9:0] cal_mag = cal[7] ? {(8'h00 - cal), 2'b00} : {cal, 2'b00};
   wire [15:0] sec_len = 16'(TICKS_PER_SEC);
   wire [15:0] half_len = 16'(TICKS_PER_SEC / 2);
   // stretch or shorten the first second of each minute by the pending amount
   wire [15:0] this_len = (min_sec_r == 6'h00 && cal != 8'h00)
                          ? (cal[7] ? sec_len - {6'h00, cal_mag} : sec_len + {6'h00, cal_mag})
                          : sec_len;
   wire sec_end = on && tick && sub_r >= this_len - 16'h0001;
   wire half_sec = sub_r >= half_len;

   wire c_min = tm_r.sec == 8'h59;
   wire c_hr = c_min && tm_r.min == 8'h59;
   wire c_day = c_hr && tm_r.hour == 8'h23;
   wire c_mon = c_day && tm_r.day >= month_end(tm_r.month, tm_r.year);
   wire c_yr = c_mon && tm_r.month == 8'h12;

   // alarm match on second, minute and hour only: compare fires once per matching second
   assign alarm_hit = sec_end && alm_cfg_r[`ALM_EN_BIT] && tm_r.sec == al_r.sec
                    && tm_r.min == al_r.min && tm_r.hour == al_r.hour;

   // ==========================================================
   // time keeping and window writes
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tm_r <= '{8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h01, 8'h00};
         sub_r <= 16'h0000;
         min_sec_r <= 6'h00;
      end
      else if (tw_l && vptr == 2'h0)
      begin
         // writing seconds byte restarts the second
         tm_r.sec <= reg_wdata[7:0];
         sub_r <= 16'h0000;
         if (tw_h || reg_byte_en[1])
            tm_r.min <= reg_wdata[15:8];
      end
      else if (tw_h || tw_l)
      begin
         // bcd pair selected by the value pointer
         unique case (vptr)
            2'h0: tm_r.min <= reg_wdata[15:8];
            2'h1:
            begin
               tm_r.wday <= reg_wdata[15:8];
               tm_r.hour <= reg_wdata[7:0];
            end
            2'h2:
            begin
               tm_r.month <= reg_wdata[15:8];
               tm_r.day <= reg_wdata[7:0];
            end
            2'h3: tm_r.year <= reg_wdata[7:0];
         endcase
      end
      else if (on && tick)
      begin
         sub_r <= sec_end ? 16'h0000 : sub_r + 16'h0001;
         if (sec_end)
         begin
            min_sec_r <= (min_sec_r == `SEC_PER_MIN) ? 6'h00 : min_sec_r + 6'h01;
            tm_r.sec <= bcd_inc(tm_r.sec, 8'h59, 8'h00);
            if (c_min)
               tm_r.min <= bcd_inc(tm_r.min, 8'h59, 8'h00);
            if (c_hr)
               tm_r.hour <= bcd_inc(tm_r.hour, 8'h23, 8'h00);
            if (c_day)
            begin
               tm_r.wday <= bcd_inc(tm_r.wday, 8'h06, 8'h00);
               tm_r.day <= bcd_inc(tm_r.day, month_end(tm_r.month, tm_r.year), 8'h01);
            end
            if (c_mon)
               tm_r.month <= bcd_inc(tm_r.month, 8'h12, 8'h01);
            if (c_yr)
               tm_r.year <= bcd_inc(tm_r.year, 8'h99, 8'h00);
         end
      end
   end

   // ==========================================================
   // alarm window writes, code 11 is empty
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         al_r <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
      else if (wr_almh || wr_alml)
      begin
         unique case (aptr)
            2'h0:
            begin
               al_r.min <= reg_wdata[15:8];
               al_r.sec <= reg_wdata[7:0];
            end
            2'h1:
            begin
               al_r.wday <= reg_wdata[15:8];
               al_r.hour <= reg_wdata[7:0];
            end
            2'h2:
            begin
               al_r.month <= reg_wdata[15:8];
               al_r.day <= reg_wdata[7:0];
            end
            2'h3: ;
         endcase
      end
   end

   // ==========================================================
   // read mux, data in the cycle after the strobe
   logic [15:0] val_win, alm_win, rd_mux;
   always_comb
   begin
      unique case (vptr)
         2'h0: val_win = {tm_r.min, tm_r.sec};
         2'h1: val_win = {tm_r.wday, tm_r.hour};
         2'h2: val_win = {tm_r.month, tm_r.day};
         2'h3: val_win = {8'h00, tm_r.year};
      endcase
      unique case (aptr)
         2'h0: alm_win = {al_r.min, al_r.sec};
         2'h1: alm_win = {al_r.wday, al_r.hour};
         2'h2: alm_win = {al_r.month, al_r.day};
         2'h3: alm_win = 16'h0000;
      endcase
      unique case (reg_addr)
         `OFS_CFG: rd_mux = {cfg_r[15], 1'b0, cfg_r[13], 1'b0, half_sec, cfg_r[10:0]};
         `OFS_VALH, `OFS_VALL: rd_mux = val_win;
         `OFS_ALMCFG: rd_mux = alm_cfg_r;
         `OFS_ALMH, `OFS_ALML: rd_mux = alm_win;
         `OFS_PAD: rd_mux = {14'h0000, pad_sel_r, 1'b0};
         `OFS_IRQ_ST: rd_mux = {14'h0000, irq_st_r};
         `OFS_IRQ_MASK: rd_mux = {14'h0000, irq_mask_r};
         default: rd_mux = 16'h0000;
      endcase
   end

   // ==========================================================
   // outputs, status and pin
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata <= 16'h0000;
         irq_st_r <= 2'h0;
         irq <= 1'b0;
         sec_clk_r <= 1'b0;
         alarm_pulse_r <= 1'b0;
         rtc_pin <= 1'b0;
      end
      else
      begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
         // set wins over write-one-to-clear: bit0 second, bit1 alarm
         irq_st_r <= (irq_st_r & ~((reg_wr && reg_addr == `OFS_IRQ_ST) ? reg_wdata[1:0] : 2'h0))
                     | {alarm_hit, sec_end};
         irq <= |(irq_st_r & irq_mask_r);
         sec_clk_r <= on & ~half_sec;
         if (alarm_hit)
            alarm_pulse_r <= ~alarm_pulse_r;
         // pin source chosen by pad select, gated by output enable
         rtc_pin <= cfg_r[`CFG_OE_BIT] & (pad_sel_r ? sec_clk_r : alarm_pulse_r);
      end
   end

   // ==========================================================
   // checks
   property p_ptr_stop;
      @(posedge core_clk) disable iff (!reset_n)
      (rd_val && !wr_cfg && vptr == 2'h0) |=> vptr == 2'h0;
   endproperty
   a_ptr_stop: assert property (p_ptr_stop) else $error("value pointer left 00");
   property p_ptr_dec;
      @(posedge core_clk) disable iff (!reset_n)
      (rd_val && !wr_cfg && vptr != 2'h0) |=> vptr == $past(vptr) - 2'h1;
   endproperty
   a_ptr_dec: assert property (p_ptr_dec) else $error("value pointer did not step");
   property p_lock;
      @(posedge core_clk) disable iff (!reset_n)
      (wr_valh && !unlocked && !on) |=> $stable(tm_r);
   endproperty
   a_lock: assert property (p_lock) else $error("locked time changed");
   property p_unlock;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(unlocked) |-> $past(key_open);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock set outside window");
   property p_on;
      @(posedge core_clk) disable iff (!reset_n)
      $changed(on) |-> $past(unlocked);
   endproperty
   a_on: assert property (p_on) else $error("module-on changed while locked");
   property p_hour;
      @(posedge core_clk) disable iff (!reset_n)
      // a time write in the same cycle wins over the roll, so it is left out
      (sec_end && c_day && !tw_h && !tw_l) |=> tm_r.hour == 8'h00;
   endproperty
   a_hour: assert property (p_hour) else $error("hour did not wrap");
   property p_leap;
      @(posedge core_clk) disable iff (!reset_n)
      (sec_end && c_day && !tw_h && !tw_l && tm_r.month == 8'h02 && tm_r.day == 8'h28
       && tm_r.year == 8'h24)
      |=> tm_r.day == 8'h29;
   endproperty
   a_leap: assert property (p_leap) else $error("leap day skipped");
   property p_half;
      @(posedge core_clk) disable iff (!reset_n)
      (tw_l && vptr == 2'h0) |=> !half_sec;
   endproperty
   a_half: assert property (p_half) else $error("half flag not cleared");
   property p_apt;
      @(posedge core_clk) disable iff (!reset_n)
      (wr_almh && !wr_acfg && aptr != 2'h0) |=> aptr == $past(aptr) - 2'h1;
   endproperty
   a_apt: assert property (p_apt) else $error("alarm pointer did not step");
endmodule
`default_nettype wire

// ### testbench/calendar_clock_tb.sv
// self-checking bench for the bcd calendar clock
`include "rtc_defines.svh"
`default_nettype none
module calendar_clock_tb
   import rtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // short second keeps the run small; calibration is idle at this count
   localparam int TICKS = 8;
   localparam int LIMIT = 20000;
   logic core_clk, reset_n, timebase_in, reg_wr, reg_rd, rtc_pin, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [1:0] reg_byte_en;
   int errors, checks_done, cycles, i;
   logic [15:0] d;
   logic p0;

   // ==========================================
   // device under test
   calendar_clock #(.TICKS_PER_SEC(TICKS)) uut
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .timebase_in(timebase_in),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_byte_en(reg_byte_en),
      .reg_rdata(reg_rdata),
      .rtc_pin(rtc_pin),
      .irq(irq)
   );

   // ==========================================
   // clocks and hang guard
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // timebase far slower than the core, one tick every 6 core cycles
   initial
   begin
      timebase_in = 1'b0;
      forever
      begin
         repeat (3) @(posedge core_clk);
         timebase_in <= ~timebase_in;
      end
   end
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         errors++;
         print_verdict();
      end
   end

   // ==========================================
   // bus and check helpers
   task automatic print_verdict();
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask
   // hold keeps the strobe up so key writes can follow back to back
   task automatic wr(input logic [3:0] a, input logic [15:0] v, input bit hold);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge core_clk);
      #1;
      if (!hold)
      begin
         reg_wr <= 1'b0;
         @(posedge core_clk);
         #1;
      end
   endtask
   task automatic rdv(input logic [3:0] a, output logic [15:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge core_clk);
      #1;
      v = reg_rdata;
      reg_rd <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp,
                        input string nm);
      logic [15:0] v;
      rdv(a, v);
      chk(nm, exp, v & m);
   endtask
   function automatic logic [15:0] cfgv(input logic on, unl, oe, input logic [1:0] p);
      cfgv = 16'h0000;
      cfgv[`CFG_ON_BIT] = on;
      cfgv[`CFG_UNLOCK_BIT] = unl;
      cfgv[`CFG_OE_BIT] = oe;
      cfgv[9:8] = p;
   endfunction
   task automatic key_seq();
      wr(`OFS_KEY, {8'h00, `KEY_FIRST}, 1);
      wr(`OFS_KEY, {8'h00, `KEY_SECOND}, 1);
   endtask

   // ==========================================
   // scenarios
   task automatic t_reset();
      chk("irq at reset", 16'h0000, {15'h0000, irq});
      rdchk(`OFS_CFG, 16'hFFFF, 16'h0000, "config at reset");
      rdchk(4'hF, 16'hFFFF, 16'h0000, "unmapped");
      wr(`OFS_CFG, cfgv(0, 0, 0, 2'h3), 0);
      rdchk(`OFS_VALH, 16'hFFFF, 16'h0000, "year pair");
      rdchk(`OFS_VALL, 16'hFFFF, 16'h0101, "month day");
      rdchk(`OFS_VALH, 16'hFFFF, 16'h0600, "weekday hour");
      rdchk(`OFS_VALL, 16'hFFFF, 16'h0000, "minute second");
      rdchk(`OFS_CFG, 16'h0300, 16'h0000, "pointer floor");
   endtask
   task automatic t_lock();
      wr(`OFS_VALH, 16'h1234, 0);
      rdchk(`OFS_VALH, 16'hFFFF, 16'h0000, "locked time");
      wr(`OFS_CFG, cfgv(1, 0, 0, 2'h0), 0);
      rdchk(`OFS_CFG, 16'h8000, 16'h0000, "locked module on");
      // a foreign write between key and unlock closes the window
      key_seq();
      wr(`OFS_PAD, 16'h0000, 1);
      wr(`OFS_CFG, cfgv(0, 1, 0, 2'h0), 0);
      rdchk(`OFS_CFG, 16'h2000, 16'h0000, "late unlock");
   endtask
   task automatic t_leap();
      key_seq();
      wr(`OFS_CFG, cfgv(0, 1, 0, 2'h3), 0);
      wr(`OFS_CFG, cfgv(1, 1, 0, 2'h3), 0);
      rdchk(`OFS_CFG, 16'hA000, 16'hA000, "unlock and on");
      wr(`OFS_VALH, 16'h0024, 0);
      wr(`OFS_VALH, 16'h0228, 0);
      wr(`OFS_VALH, 16'h0323, 0);
      wr(`OFS_VALH, 16'h5959, 0);
      wr(`OFS_VALL, 16'h5959, 0);
      rdchk(`OFS_CFG, 16'h0B00, 16'h0000, "pointer and half");
      d = 16'hFFFF;
      for (i = 0; i < 300 && d[7:0] !== 8'h00; i++) rdv(`OFS_VALH, d);
      wr(`OFS_CFG, cfgv(1, 1, 0, 2'h3), 0);
      rdchk(`OFS_VALH, 16'hFFFF, 16'h0024, "year");
      rdchk(`OFS_VALL, 16'hFFFF, 16'h0229, "leap day");
      rdchk(`OFS_VALH, 16'hFFFF, 16'h0400, "weekday hour");
      rdchk(`OFS_VALL, 16'hFFFF, 16'h0000, "minute second");
      d = 16'h0000;
      for (i = 0; i < 100 && d[`CFG_HALF_BIT] !== 1'b1; i++) rdv(`OFS_CFG, d);
      chk("half second", 16'h0800, d & 16'h0800);
   endtask
   task automatic t_alarm_window();
      wr(`OFS_ALMCFG, 16'h0200, 0);
      wr(`OFS_ALML, 16'h0315, 0);
      wr(`OFS_ALMH, 16'h0316, 0);
      wr(`OFS_ALMH, 16'h0212, 0);
      wr(`OFS_ALMH, 16'h3010, 0);
      wr(`OFS_ALML, 16'h3011, 0);
      wr(`OFS_ALMCFG, 16'h0300, 0);
      rdchk(`OFS_ALMH, 16'hFFFF, 16'h0000, "empty alarm pair");
      rdchk(`OFS_ALML, 16'hFFFF, 16'h0316, "alarm month day");
      rdchk(`OFS_ALMH, 16'hFFFF, 16'h0212, "alarm weekday hour");
      rdchk(`OFS_ALMH, 16'hFFFF, 16'h3011, "alarm minute second");
      rdchk(`OFS_ALML, 16'hFFFF, 16'h3011, "alarm floor");
   endtask
   task automatic t_alarm_irq();
      wr(`OFS_CFG, cfgv(1, 1, 1, 2'h1), 0);
      wr(`OFS_VALH, 16'h0412, 0);
      wr(`OFS_VALH, 16'h3009, 0);
      wr(`OFS_VALL, 16'h3009, 0);
      wr(`OFS_IRQ_MASK, 16'h0002, 0);
      wr(`OFS_IRQ_ST, 16'h0003, 0);
      p0 = rtc_pin;
      wr(`OFS_ALMCFG, 16'h8000, 0);
      for (i = 0; i < 400 && irq !== 1'b1; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk("alarm irq", 16'h0001, {15'h0000, irq});
      rdchk(`OFS_IRQ_ST, 16'h0002, 16'h0002, "alarm status");
      chk("alarm pulse", {15'h0000, ~p0}, {15'h0000, rtc_pin});
      wr(`OFS_IRQ_ST, 16'h0002, 0);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      // masked events still latch but keep the line low
      wr(`OFS_IRQ_MASK, 16'h0000, 0);
      d = 16'h0000;
      for (i = 0; i < 100 && d[0] !== 1'b1; i++) rdv(`OFS_IRQ_ST, d);
      chk("second status", 16'h0001, d & 16'h0001);
      chk("masked irq", 16'h0000, {15'h0000, irq});
   endtask
   task automatic t_sec_clock();
      wr(`OFS_PAD, 16'h0002, 0);
      p0 = rtc_pin;
      for (i = 0; i < 100 && rtc_pin === p0; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk("seconds clock", {15'h0000, ~p0}, {15'h0000, rtc_pin});
      wr(`OFS_CFG, cfgv(1, 1, 0, 2'h0), 0);
      chk("pin disabled", 16'h0000, {15'h0000, rtc_pin});
      wr(`OFS_CFG, cfgv(1, 0, 0, 2'h0), 0);
      rdchk(`OFS_CFG, 16'hA000, 16'h8000, "relocked");
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      errors = 0;
      checks_done = 0;
      cycles = 0;
      reset_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_byte_en = 2'h3;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      #1;
      t_reset();
      t_lock();
      t_leap();
      t_alarm_window();
      t_alarm_irq();
      t_sec_clock();
      print_verdict();
   end
endmodule
`default_nettype wire
